/* File: pkg/iwc_pkg.sv */
// package: constants for the interrupt, watchdog and comparator control block
package iwc_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned NUM_IRQ         = 12;
    localparam logic [10:0] TRAP_VECTOR     = 11'h001;
    localparam logic [10:0] HW_VECTOR       = 11'h008;
    // flag bit positions; watchdog sits at bit 6 as in the flag register
    localparam int unsigned IRQ_TMR0        = 0;
    localparam int unsigned IRQ_TMR1        = 1;
    localparam int unsigned IRQ_TMR2        = 2;
    localparam int unsigned IRQ_TMR3        = 3;
    localparam int unsigned IRQ_TMR4        = 4;
    localparam int unsigned IRQ_TMR5        = 5;
    localparam int unsigned IRQ_WDT         = 6;
    localparam int unsigned IRQ_PAB         = 7;
    localparam int unsigned IRQ_EXT0        = 8;
    localparam int unsigned IRQ_EXT1        = 9;
    localparam int unsigned IRQ_LVD         = 10;
    localparam int unsigned IRQ_CMP         = 11;
    localparam int unsigned CMP_RESULT_BIT  = 7;
    localparam int unsigned CMP_OE_BIT      = 6;
    localparam logic        CMP_EN_RESET    = 1'b0;
    localparam logic        TO_FLAG_RESET   = 1'b1;
    localparam logic        GIE_RESET       = 1'b0;
    localparam logic [3:0]  NO_PAD          = 4'hf;
    // base timeouts in microseconds, selected by two configuration bits
    localparam int unsigned WDT_US_0        = 3500;
    localparam int unsigned WDT_US_1        = 15000;
    localparam int unsigned WDT_US_2        = 60000;
    localparam int unsigned WDT_US_3        = 250000;
    localparam int unsigned WDT_CYC_0       = WDT_US_0 * (CLK_HZ / 1_000_000);
    localparam int unsigned WDT_CYC_1       = WDT_US_1 * (CLK_HZ / 1_000_000);
    localparam int unsigned WDT_CYC_2       = WDT_US_2 * (CLK_HZ / 1_000_000);
    localparam int unsigned WDT_CYC_3       = WDT_US_3 * (CLK_HZ / 1_000_000);
    localparam int unsigned WDT_CNT_W       = 24;
    localparam int unsigned PRE_W           = 8;
    typedef enum logic [2:0] {
        IWC_IDLE  = 3'b001,
        IWC_TRAP  = 3'b010,
        IWC_HWIRQ = 3'b100
    } iwc_vec_state_t;
endpackage

/* File: core/iwc_pad_route.sv */
// module: comparator input routing for both comparing modes
`timescale 1ns/1ps
module iwc_pad_route (
    input  wire logic [3:0] reference_level_select,
    input  wire logic [3:0] comparator_pad_select,
    output logic            pad_to_pad_mode,
    output logic            pad_to_reference_mode,
    output logic [3:0]      noninv_pad,
    output logic [3:0]      inv_pad,
    output logic [3:0]      ref_code
);
    // pad codes: 0..7 = A0..A7, 8..13 = B0..B5, f = none
    function automatic logic [7:0] p2p_pair(input logic [3:0] sel);
        case (sel)
            4'h0: p2p_pair = {4'h0, 4'h1};
            4'h1: p2p_pair = {4'h1, 4'h0};
            4'h2: p2p_pair = {4'h2, 4'h3};
            4'h3: p2p_pair = {4'h3, 4'h2};
            4'h4: p2p_pair = {4'h0, 4'hb};
            4'h5: p2p_pair = {4'h1, 4'ha};
            4'h6: p2p_pair = {4'h2, 4'hd};
            4'h7: p2p_pair = {4'h3, 4'hc};
            4'h8: p2p_pair = {4'ha, 4'h1};
            4'h9: p2p_pair = {4'hb, 4'h0};
            4'ha: p2p_pair = {4'hc, 4'h3};
            4'hb: p2p_pair = {4'hd, 4'h2};
            4'hc: p2p_pair = {4'ha, 4'hb};
            4'hd: p2p_pair = {4'hb, 4'ha};
            4'he: p2p_pair = {4'hc, 4'hd};
            default: p2p_pair = {4'hd, 4'hc};
        endcase
    endfunction

    always_comb begin
        pad_to_pad_mode       = (reference_level_select == 4'h0);
        pad_to_reference_mode = !pad_to_pad_mode;
        ref_code              = pad_to_reference_mode ? reference_level_select : 4'h0;
        if (pad_to_pad_mode) begin
            {noninv_pad, inv_pad} = p2p_pair(comparator_pad_select);
        end else begin
            inv_pad = iwc_pkg::NO_PAD;
            // codes 5 and 14..15 select no pad
            if (comparator_pad_select == 4'h5 || comparator_pad_select[3:1] == 3'b111) begin
                noninv_pad = iwc_pkg::NO_PAD;
            end else if (comparator_pad_select[3]) begin
                noninv_pad = comparator_pad_select;
            end else begin
                noninv_pad = comparator_pad_select;
            end
        end
    end
endmodule

/* File: core/iwc_ctrl.sv */
// module: interrupt controller, watchdog timeout and comparator digital control
`timescale 1ns/1ps
// Function
// - comparator enable resets off, power forced off halted
// - zero reference select means pad-to-pad mode
// - drive reference code to ladder in reference mode
// - pad select picks one of thirteen pads
// - pad-to-pad codes decode to fixed pad pairs
// - status read refreshes registered comparator copy
// - mismatch with copy sets comparator change flag
// - live comparator result readable at status bit 7
// - output enable puts result on probe pad
// - configuration enables watchdog, run bit gates counting
// - timeout resets or interrupts, clears timeout flag
// - base timeout is one of four periods
// - prescaler assignment extends timeout by ratio
// - clear instruction zeroes counters, sets timeout flag when prescaler assigned
// - interrupt-mode expiry sets watchdog flag
// - twelve hardware interrupt sources accepted
// - global enable set, cleared by instructions
// - trap vectors to 0x001, clears global enable
// - return sets global enable and resumes
// - flags stay set until firmware writes zero
// - flag reads back only when enabled
// - enabled pending flag vectors to 0x008
module iwc_ctrl (
    input  wire logic                  clock,
    input  wire logic                  srst,
    // processor side
    input  wire logic                  trap_instruction,
    input  wire logic                  enable_interrupts_instruction,
    input  wire logic                  disable_interrupts_instruction,
    input  wire logic                  return_from_interrupt_instruction,
    input  wire logic                  watchdog_clear_instruction,
    input  wire logic                  vector_taken,
    output logic                       vector_request,
    output logic [10:0]                vector_address,
    output logic                       global_irq_enable,
    // interrupt flag and enable registers
    input  wire logic [11:0]           irq_events,
    input  wire logic [11:0]           interrupt_enable_reg,
    input  wire logic                  flag_write,
    input  wire logic [11:0]           flag_write_data,
    output logic [11:0]                interrupt_flag_reg,
    // watchdog configuration and control
    input  wire logic                  cfg_watchdog_enable,
    input  wire logic                  cfg_watchdog_irq_mode,
    input  wire logic [1:0]            cfg_watchdog_period,
    input  wire logic                  watchdog_run_enable,
    input  wire logic                  prescaler_to_watchdog_assign,
    input  wire logic [2:0]            prescaler_ratio_select,
    output logic                       watchdog_reset_pulse,
    output logic                       timeout_status_flag,
    // comparator
    input  wire logic                  comparator_enable_wr,
    input  wire logic                  comparator_enable_data,
    input  wire logic                  halt_mode,
    input  wire logic [7:0]            comparator_control_reg,
    input  wire logic                  comparator_pad_output_enable,
    input  wire logic                  status_read,
    input  wire logic                  comparator_analog_out,
    input  wire logic                  first_pwm_output,
    output logic                       comparator_enable,
    output logic                       comparator_power,
    output logic                       pad_to_pad_mode,
    output logic [3:0]                 reference_level_select,
    output logic [3:0]                 noninv_pad_select,
    output logic [3:0]                 inv_pad_select,
    output logic [7:0]                 oscillator_comparator_status_reg,
    output logic                       comparator_probe_pad
);
    localparam int unsigned WDT_W = iwc_pkg::WDT_CNT_W;

    logic        cmp_en_q;
    logic        cmp_meta_q;
    logic        cmp_sync_q;
    logic        cmp_copy_q;
    logic [11:0] flag_q;
    logic        gie_q;
    logic        to_q;
    logic        wdt_rst_q;
    logic [WDT_W-1:0] wdt_cnt_q;
    logic [7:0]  pre_q;
    logic [10:0] vec_addr_q;
    logic        probe_q;
    logic [7:0]  status_q;
    logic [3:0]  np_w;
    logic [3:0]  ip_w;
    logic [3:0]  rc_w;
    logic        p2p_w;
    logic        p2v_w;
    logic        wdt_tick;
    logic        wdt_expire;
    logic        pending;
    logic [11:0] hw_set;
    iwc_pkg::iwc_vec_state_t vst_q;

    function automatic logic [WDT_W-1:0] wdt_base(input logic [1:0] sel);
        case (sel)
            2'h0:    wdt_base = WDT_W'(iwc_pkg::WDT_CYC_0 - 1);
            2'h1:    wdt_base = WDT_W'(iwc_pkg::WDT_CYC_1 - 1);
            2'h2:    wdt_base = WDT_W'(iwc_pkg::WDT_CYC_2 - 1);
            default: wdt_base = WDT_W'(iwc_pkg::WDT_CYC_3 - 1);
        endcase
    endfunction

    iwc_pad_route u_route (
        .reference_level_select (comparator_control_reg[3:0]),
        .comparator_pad_select  (comparator_control_reg[7:4]),
        .pad_to_pad_mode        (p2p_w),
        .pad_to_reference_mode  (p2v_w),
        .noninv_pad             (np_w),
        .inv_pad                (ip_w),
        .ref_code               (rc_w)
    );

    // ---------------- comparator ----------------
    always_ff @(posedge clock) begin
        if (srst) begin
            cmp_en_q <= iwc_pkg::CMP_EN_RESET;
        end else if (comparator_enable_wr) begin
            cmp_en_q <= comparator_enable_data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= comparator_analog_out;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cmp_copy_q <= 1'b0;
        end else if (status_read) begin
            cmp_copy_q <= cmp_sync_q;
        end
    end

    // status bits below the result and output enable read zero
    always_ff @(posedge clock) begin
        if (srst) begin
            status_q <= 8'h00;
            probe_q  <= 1'b0;
        end else begin
            status_q <= 8'h00;
            status_q[iwc_pkg::CMP_RESULT_BIT] <= cmp_sync_q;
            status_q[iwc_pkg::CMP_OE_BIT]     <= comparator_pad_output_enable;
            // pwm function is displaced while the probe is enabled
            probe_q <= comparator_pad_output_enable ? cmp_sync_q : first_pwm_output;
        end
    end

    // ---------------- watchdog ----------------
    // ratio 1:1..1:128 in reset mode, 1:2..1:256 in interrupt mode
    always_comb begin
        logic [8:0] lim;
        lim = 9'h000;
        if (!prescaler_to_watchdog_assign) begin
            wdt_tick = 1'b1;
        end else begin
            lim = cfg_watchdog_irq_mode ? (9'h002 << prescaler_ratio_select)
                                        : (9'h001 << prescaler_ratio_select);
            wdt_tick = ({1'b0, pre_q} == lim - 9'h001);
        end
    end

    assign wdt_expire = cfg_watchdog_enable && watchdog_run_enable && wdt_tick
                        && (wdt_cnt_q == wdt_base(cfg_watchdog_period));

    always_ff @(posedge clock) begin
        if (srst || watchdog_clear_instruction) begin
            pre_q     <= 8'h00;
            wdt_cnt_q <= '0;
        end else if (cfg_watchdog_enable && watchdog_run_enable) begin
            pre_q <= wdt_tick ? 8'h00 : pre_q + 8'h01;
            if (wdt_tick) begin
                wdt_cnt_q <= wdt_expire ? '0 : wdt_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            to_q      <= iwc_pkg::TO_FLAG_RESET;
            wdt_rst_q <= 1'b0;
        end else begin
            wdt_rst_q <= wdt_expire && !cfg_watchdog_irq_mode;
            if (wdt_expire) begin
                to_q <= 1'b0;
            end else if (watchdog_clear_instruction && prescaler_to_watchdog_assign) begin
                to_q <= 1'b1;
            end
        end
    end

    // ---------------- interrupt flags ----------------
    always_comb begin
        hw_set = irq_events;
        hw_set[iwc_pkg::IRQ_WDT] = wdt_expire && cfg_watchdog_irq_mode;
        hw_set[iwc_pkg::IRQ_CMP] = cmp_en_q && !halt_mode && (cmp_sync_q != cmp_copy_q);
    end

    genvar gi;
    generate
        for (gi = 0; gi < iwc_pkg::NUM_IRQ; gi++) begin : g_flag
            // a set in the same cycle as a firmware clear wins
            always_ff @(posedge clock) begin
                if (srst) begin
                    flag_q[gi] <= 1'b0;
                end else if (hw_set[gi]) begin
                    flag_q[gi] <= 1'b1;
                end else if (flag_write && !flag_write_data[gi]) begin
                    flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign pending = |(flag_q & interrupt_enable_reg);

    // ---------------- global enable and vectoring ----------------
    always_ff @(posedge clock) begin
        if (srst) begin
            gie_q <= iwc_pkg::GIE_RESET;
        end else if (trap_instruction) begin
            gie_q <= 1'b0;
        end else if (vst_q == iwc_pkg::IWC_IDLE && gie_q && pending) begin
            gie_q <= 1'b0;
        end else if (enable_interrupts_instruction || return_from_interrupt_instruction) begin
            gie_q <= 1'b1;
        end else if (disable_interrupts_instruction) begin
            gie_q <= 1'b0;
        end
    end

    // the vector request holds until the fetch logic takes it
    always_ff @(posedge clock) begin
        if (srst) begin
            vst_q      <= iwc_pkg::IWC_IDLE;
            vec_addr_q <= 11'h000;
        end else begin
            case (vst_q)
                iwc_pkg::IWC_IDLE: begin
                    if (trap_instruction) begin
                        vst_q      <= iwc_pkg::IWC_TRAP;
                        vec_addr_q <= iwc_pkg::TRAP_VECTOR;
                    end else if (gie_q && pending) begin
                        vst_q      <= iwc_pkg::IWC_HWIRQ;
                        vec_addr_q <= iwc_pkg::HW_VECTOR;
                    end
                end
                iwc_pkg::IWC_TRAP, iwc_pkg::IWC_HWIRQ: begin
                    if (vector_taken) begin
                        vst_q <= iwc_pkg::IWC_IDLE;
                    end
                end
                default: vst_q <= iwc_pkg::IWC_IDLE;
            endcase
        end
    end

    assign vector_request      = (vst_q != iwc_pkg::IWC_IDLE);
    assign vector_address      = vec_addr_q;
    assign global_irq_enable   = gie_q;
    assign interrupt_flag_reg  = flag_q & interrupt_enable_reg;
    assign watchdog_reset_pulse = wdt_rst_q;
    assign timeout_status_flag = to_q;
    assign comparator_enable   = cmp_en_q;
    assign comparator_power    = cmp_en_q && !halt_mode;
    assign pad_to_pad_mode     = p2p_w;
    assign reference_level_select = rc_w;
    assign noninv_pad_select   = np_w;
    assign inv_pad_select      = ip_w;
    assign oscillator_comparator_status_reg = status_q;
    assign comparator_probe_pad = probe_q;

    // ---------------- assertions ----------------
    a_trap_vector: assert property (@(posedge clock) disable iff (srst)
        trap_instruction && vst_q == iwc_pkg::IWC_IDLE |=> vector_request
        && vector_address == 11'h001 && !global_irq_enable)
        else $error("trap did not vector to 001");
    a_hw_vector: assert property (@(posedge clock) disable iff (srst)
        !trap_instruction && vst_q == iwc_pkg::IWC_IDLE && gie_q && pending
        |=> vector_request && vector_address == 11'h008 && !gie_q)
        else $error("hardware interrupt did not vector to 008");
    a_flag_sticky: assert property (@(posedge clock) disable iff (srst)
        flag_q[0] && !(flag_write && !flag_write_data[0]) |=> flag_q[0])
        else $error("flag cleared without firmware write");
    a_flag_readback: assert property (@(posedge clock) disable iff (srst)
        !interrupt_enable_reg[3] |-> !interrupt_flag_reg[3])
        else $error("disabled flag visible");
    a_cmp_mismatch: assert property (@(posedge clock) disable iff (srst)
        cmp_en_q && !halt_mode && cmp_sync_q != cmp_copy_q |=> flag_q[iwc_pkg::IRQ_CMP])
        else $error("comparator change not flagged");
    a_cmp_refresh: assert property (@(posedge clock) disable iff (srst)
        status_read |=> cmp_copy_q == $past(cmp_sync_q))
        else $error("status read did not refresh copy");
    a_cmp_halt: assert property (@(posedge clock) disable iff (srst)
        halt_mode |-> !comparator_power)
        else $error("comparator powered in halt");
    a_sync_path: assert property (@(posedge clock) disable iff (srst)
        ##2 cmp_sync_q == $past(comparator_analog_out, 2))
        else $error("comparator sync depth wrong");
    a_wdt_timeout: assert property (@(posedge clock) disable iff (srst)
        wdt_expire |=> !timeout_status_flag
        && (watchdog_reset_pulse == !$past(cfg_watchdog_irq_mode)))
        else $error("timeout handling wrong");
    a_wdt_clear: assert property (@(posedge clock) disable iff (srst)
        watchdog_clear_instruction |=> wdt_cnt_q == '0 && pre_q == 8'h00)
        else $error("clear did not zero counters");
    a_gie_return: assert property (@(posedge clock) disable iff (srst)
        return_from_interrupt_instruction && !trap_instruction && !(gie_q && pending
        && vst_q == iwc_pkg::IWC_IDLE) |=> global_irq_enable)
        else $error("return did not set global enable");
endmodule

/* File: sim/iwc_core_model.sv */
// processor core model: accepts the vector after a chosen number of cycles
`timescale 1ns/1ps
module iwc_core_model (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       vector_request,
    input  wire logic [3:0] take_delay,
    output logic            vector_taken
);
    logic [3:0] wait_q;
    logic       taken_q;
    // one accept per request; the request is still high for a cycle after the accept
    always_ff @(posedge clock) begin
        if (srst || !vector_request) begin
            wait_q       <= 4'h0;
            taken_q      <= 1'b0;
            vector_taken <= 1'b0;
        end else if (!taken_q && wait_q == take_delay) begin
            taken_q      <= 1'b1;
            vector_taken <= 1'b1;
        end else begin
            wait_q       <= wait_q + 4'h1;
            vector_taken <= 1'b0;
        end
    end
endmodule

/* File: sim/test_iwc_ctrl.sv */
// bench: self-checking stimulus for the interrupt, watchdog and comparator block
`timescale 1ns/1ps
module test_iwc_ctrl;
    localparam logic [63:0] P2P_N = 64'hdcba_dcba_3210_3210;
    localparam logic [63:0] P2P_I = 64'hcdab_2301_cdab_2301;
    localparam logic [63:0] REF_N = 64'hffdc_ba98_76f4_3210;
    logic        clock, srst, vector_taken, vector_request, global_irq_enable, flag_write;
    logic        cfg_watchdog_enable, cfg_watchdog_irq_mode, watchdog_run_enable;
    logic        prescaler_to_watchdog_assign, watchdog_reset_pulse, timeout_status_flag;
    logic        comparator_enable_wr, comparator_enable_data, halt_mode, status_read;
    logic        comparator_pad_output_enable, comparator_analog_out, first_pwm_output;
    logic        comparator_enable, comparator_power, pad_to_pad_mode, comparator_probe_pad;
    logic [1:0]  cfg_watchdog_period;
    logic [2:0]  prescaler_ratio_select;
    logic [3:0]  reference_level_select, noninv_pad_select, inv_pad_select, take_delay;
    logic [4:0]  iv;
    logic [7:0]  comparator_control_reg, oscillator_comparator_status_reg;
    logic [10:0] vector_address;
    logic [11:0] irq_events, interrupt_enable_reg, flag_write_data, interrupt_flag_reg;
    logic [11:0] exp_q[$];
    int          n_errors, check_count, seed, cycles;

    iwc_ctrl i_iwc_ctrl (.clock, .srst, .trap_instruction(iv[0]),
        .enable_interrupts_instruction(iv[1]), .disable_interrupts_instruction(iv[2]),
        .return_from_interrupt_instruction(iv[3]), .watchdog_clear_instruction(iv[4]),
        .vector_taken, .vector_request, .vector_address, .global_irq_enable, .irq_events,
        .interrupt_enable_reg, .flag_write, .flag_write_data, .interrupt_flag_reg,
        .cfg_watchdog_enable, .cfg_watchdog_irq_mode, .cfg_watchdog_period,
        .watchdog_run_enable, .prescaler_to_watchdog_assign, .prescaler_ratio_select,
        .watchdog_reset_pulse, .timeout_status_flag, .comparator_enable_wr,
        .comparator_enable_data, .halt_mode, .comparator_control_reg,
        .comparator_pad_output_enable, .status_read, .comparator_analog_out,
        .first_pwm_output, .comparator_enable, .comparator_power, .pad_to_pad_mode,
        .reference_level_select, .noninv_pad_select, .inv_pad_select,
        .oscillator_comparator_status_reg, .comparator_probe_pad);
    iwc_core_model i_iwc_core_model (.clock, .srst, .vector_request, .take_delay,
        .vector_taken);

    task check(input string what, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // k: 0 trap, 1 enable, 2 disable, 3 return, 4 watchdog clear
    task instr(input int k);
        iv = 5'h1 << k;
        tick(1);
        iv = 5'h0;
        // one idle edge so back-to-back calls never retime the strobe in one step
        tick(1);
    endtask
    task wait_vec;
        for (int i = 0; i < 40 && !vector_request; i++) tick(1);
        for (int i = 0; i < 40 && vector_request; i++) tick(1);
        check("vector released", 12'h000, 12'(vector_request));
    endtask
    task clear_flags(input logic [11:0] m);
        flag_write_data = ~m;
        flag_write = 1'b1;
        tick(1);
        flag_write = 1'b0;
        tick(1);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test;
        end
    end
    // each vector the core sees must have been announced beforehand
    always @(posedge vector_request) begin
        #1;
        if (exp_q.size() == 0) check("unexpected vector", 12'h7ff, 12'(vector_address));
        else check("vector_address", exp_q.pop_front(), 12'(vector_address));
    end

    initial begin
        {clock, iv, take_delay, seed, srst} = {1'b0, 5'h0, 4'h2, 32'd20, 1'b1};
        {flag_write, comparator_enable_wr, comparator_enable_data, halt_mode} = 4'h0;
        {status_read, comparator_pad_output_enable, comparator_analog_out} = 3'h0;
        {irq_events, interrupt_enable_reg, flag_write_data} = 36'h0;
        {first_pwm_output, comparator_control_reg, cfg_watchdog_period} = 11'h0;
        {cfg_watchdog_enable, cfg_watchdog_irq_mode, watchdog_run_enable} = 3'b110;
        {prescaler_to_watchdog_assign, prescaler_ratio_select} = 4'hf;
        tick(11);
        check("reset state", 12'h001, 12'({global_irq_enable, comparator_enable,
            vector_request, timeout_status_flag}));
        check("reset status", 12'h000, 12'(oscillator_comparator_status_reg));
        tick(1);
        srst = 1'b0;
        exp_q.push_back(12'h001);
        instr(0);
        wait_vec();
        check("gie after trap", 12'h000, 12'(global_irq_enable));
        instr(3);
        check("gie after return", 12'h001, 12'(global_irq_enable));
        instr(2);
        check("gie after disable", 12'h000, 12'(global_irq_enable));
        instr(1);
        check("gie after enable", 12'h001, 12'(global_irq_enable));
        exp_q.push_back(12'h001);
        instr(0);
        wait_vec();
        check("gie after second trap", 12'h000, 12'(global_irq_enable));
        $display("trap test done");
        for (int s = 0; s < 12; s++) begin
            if (s == 6 || s == 11) continue;
            interrupt_enable_reg = 12'($random(seed)) & ~(12'h1 << s);
            irq_events = 12'h1 << s;
            tick(1);
            irq_events = 12'h0;
            tick(3);
            check("flag masked", 12'h000, interrupt_flag_reg);
            interrupt_enable_reg[s] = 1'b1;
            tick(1);
            check("flag held", 12'h1 << s, interrupt_flag_reg & (12'h1 << s));
            clear_flags(12'h1 << s);
            check("flag cleared", 12'h000, interrupt_flag_reg);
        end
        $display("flag test done");
        take_delay = 4'($random(seed)) & 4'h7;
        interrupt_enable_reg = 12'h001;
        irq_events = 12'h001;
        tick(1);
        irq_events = 12'h0;
        // global enable is off: the pending flag must wait
        tick(5);
        exp_q.push_back(12'h008);
        instr(1);
        wait_vec();
        check("gie after hw vector", 12'h000, 12'(global_irq_enable));
        clear_flags(12'h001);
        instr(3);
        tick(3);
        check("gie after hw return", 12'h001, 12'(global_irq_enable));
        instr(2);
        $display("hardware vector test done");
        comparator_enable_data = 1'b1;
        comparator_enable_wr = 1'b1;
        tick(1);
        comparator_enable_wr = 1'b0;
        tick(1);
        check("cmp on", 12'h003, 12'({comparator_enable, comparator_power}));
        halt_mode = 1'b1;
        tick(1);
        check("cmp halted", 12'h002, 12'({comparator_enable, comparator_power}));
        halt_mode = 1'b0;
        for (int c = 0; c < 16; c++) begin
            comparator_control_reg = {4'(c), 4'h0};
            tick(1);
            check("pad pair", 12'({1'b1, P2P_N[c*4+:4], P2P_I[c*4+:4]}), 12'({pad_to_pad_mode,
                noninv_pad_select, inv_pad_select}));
            comparator_control_reg = {4'(c), 4'($random(seed)) | 4'h1};
            tick(1);
            check("ref pad", 12'({1'b0, REF_N[c*4+:4], comparator_control_reg[3:0]}),
                12'({pad_to_pad_mode, noninv_pad_select,
                reference_level_select}));
        end
        interrupt_enable_reg = 12'h800;
        comparator_analog_out = 1'b1;
        tick(2);
        check("cmp result early", 12'h000, 12'(oscillator_comparator_status_reg));
        tick(2);
        check("cmp result", 12'h080, 12'(oscillator_comparator_status_reg));
        check("cmp change", 12'h800, interrupt_flag_reg);
        status_read = 1'b1;
        tick(1);
        status_read = 1'b0;
        tick(1);
        clear_flags(12'h800);
        tick(3);
        check("cmp copy refreshed", 12'h000, interrupt_flag_reg);
        {first_pwm_output, comparator_analog_out} = 2'b10;
        tick(5);
        check("probe pwm", 12'h001, 12'(comparator_probe_pad));
        comparator_pad_output_enable = 1'b1;
        tick(2);
        check("probe cmp", 12'h040, 12'({comparator_probe_pad,
            oscillator_comparator_status_reg}));
        $display("comparator test done");
        instr(4);
        tick(2);
        check("watchdog held", 12'h001, 12'({watchdog_reset_pulse,
            timeout_status_flag}));
        check("vectors outstanding", 12'h000, 12'(exp_q.size()));
        $display("watchdog test done");
        finish_test;
    end
endmodule
